// file: lics_sequencer.sv
/*
  charge-cycle sequencer for a single-cell charger: phase machine,
  charge timer, fault and indicator logic, AXI4-Lite registers.
  assumes comparator inputs from the analog front end, a 40 MHz
  clock and an asynchronous active-low reset from undervoltage.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "lics_consts.svh"
module lics_sequencer #(
  // cycles per timer second; shorten for simulation
  parameter int unsigned P_SEC_CYC = 32'(`LICS_SEC_CYC)
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_resetn,
  // comparator decisions
  input  wire lics_pkg::lics_cmp_t i_cmp,
  // indicator pins: level read back, driven level, enable
  input  wire logic [3:0]          i_ind_in,
  output lics_pkg::lics_ind_t      o_ind,
  // to the analog loop
  output lics_pkg::lics_state_t    o_phase,
  output logic                     o_out_en,
  // axi4-lite slave
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [3:0]          i_s_axi_awaddr,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  output logic                     o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  output logic [1:0]               o_s_axi_bresp,
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  input  wire logic [3:0]          i_s_axi_araddr,
  output logic                     o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready,
  output logic [31:0]              o_s_axi_rdata,
  output logic [1:0]               o_s_axi_rresp
);
  import lics_pkg::*;

  // lane merge for a byte-enabled write
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  lics_cmp_t   c;             // synchronised comparators
  lics_state_t st_r;          // current phase
  lics_state_t st_nxt;
  lics_state_t sav_r;         // phase frozen by a temperature hold
  lics_state_t sav_nxt;
  logic [31:0] div_r;         // cycles within the current second
  logic [15:0] tmr_r;         // charge timer, seconds of on-time
  logic        tick_w;        // one-cycle second enable
  logic        tmr_clr_w;     // timer back to zero
  logic        term_r;        // termination current seen in cv
  logic        term_nxt;
  logic        ctrl_en_r;     // software charge enable
  logic [15:0] rohm_r;        // timer resistor value, ohms
  lics_tmode_t tmode_w;
  logic [15:0] tlim_w;        // active timeout, seconds
  logic        tmr_on_w;      // timer in use
  logic        expired_w;
  logic        pre_over_w;    // pre-charge used a quarter
  logic        temp_bad_w;
  logic        charging_w;
  logic        fault_w;
  logic        chg_act_w;

  lics_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_cmp),
    .o_sync     (c)
  );

  // timer source from the select pin
  assign tmode_w = c.tsel_high ? TM_FIXED :
                   c.tsel_low  ? TM_OFF   : TM_RES;
  // resistor timeout: ohms / 3 seconds
  assign tlim_w  = (tmode_w == TM_FIXED) ? `LICS_T_FIXED_S :
                   16'(rohm_r / 16'h0003);
  assign tmr_on_w   = (tmode_w != TM_OFF);
  assign expired_w  = tmr_on_w && (tmr_r >= tlim_w);
  // quarter of the total charge time
  assign pre_over_w = tmr_on_w && (tmr_r >= {2'b00, tlim_w[15:2]});
  assign temp_bad_w = c.therm_cold || c.therm_hot;
  assign charging_w = (st_r == ST_PRE) || (st_r == ST_CC) ||
                      (st_r == ST_CV);
  // the timer base runs only while the output is on
  assign tick_w = charging_w && (div_r == P_SEC_CYC - 32'd1);

  // phase machine; order of tests sets the priority
  always_comb begin
    st_nxt    = st_r;
    sav_nxt   = sav_r;
    term_nxt  = term_r;
    tmr_clr_w = 1'b0;
    if (!c.supply_ok || c.therm_dis || !ctrl_en_r) begin
      // disable level: shut down, clear the timer
      // supply removal also drops a pre-charge fault
      st_nxt    = ST_OFF;
      term_nxt  = 1'b0;
      tmr_clr_w = 1'b1;
    end else if (charging_w && temp_bad_w) begin
      // suspend and freeze; above the pre, cc and cv phase tests
      sav_nxt = st_r;
      st_nxt  = ST_SUSP;
    end else begin
      case (st_r)
        ST_OFF: begin
          // new cycle on the filtered supply
          tmr_clr_w = 1'b1;
          st_nxt = c.bat_pre ? ST_CC : ST_PRE;
        end
        ST_PRE: begin
          if (c.bat_pre) begin
            st_nxt = ST_CC;
          end else if (pre_over_w) begin
            st_nxt = ST_FLT;
          end
        end
        ST_CC: begin
          if (expired_w) begin
            st_nxt = ST_MON;
          end else if (c.bat_cv) begin
            st_nxt = ST_CV;
          end
        end
        ST_CV: begin
          if (c.iout_term) begin
            term_nxt = 1'b1;
          end
          if (expired_w) begin
            st_nxt = ST_MON;
          end else if (!tmr_on_w && c.iout_term) begin
            st_nxt = ST_MON;
          end
        end
        ST_MON: begin
          if (c.bat_rechg) begin
            tmr_clr_w = 1'b1;
            term_nxt  = 1'b0;
            st_nxt    = c.bat_pre ? ST_CC : ST_PRE;
          end
        end
        ST_FLT: begin
          if (c.bat_pre) begin
            st_nxt = ST_CC;
          end
        end
        ST_SUSP: begin
          if (!temp_bad_w) begin
            st_nxt = sav_r;
          end
        end
        default: begin
          st_nxt = ST_OFF;
        end
      endcase
    end
  end

  // phase registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r   <= ST_OFF;
      sav_r  <= ST_OFF;
      term_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      sav_r  <= sav_nxt;
      term_r <= term_nxt;
    end
  end

  // second divider, cleared with the timer, otherwise held while the output is off
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_r <= 32'd0;
    end else if (tmr_clr_w || tick_w) begin
      div_r <= 32'd0;
    end else if (charging_w) begin
      div_r <= div_r + 32'd1;
    end
  end

  // charge timer counts on-time seconds only
  // saturates so a long untimed charge cannot wrap it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tmr_r <= 16'h0000;
    end else if (tmr_clr_w) begin
      tmr_r <= 16'h0000;
    end else if (tick_w && tmr_r != 16'hFFFF) begin
      tmr_r <= tmr_r + 16'h0001;
    end
  end

  // output and charge-active follow the phase
  assign chg_act_w = charging_w && !c.iout_term;
  assign fault_w   = (st_r == ST_FLT) ||
                     (temp_bad_w && c.supply_ok && !c.therm_dis);

  // outputs and indicator pins from flip-flops
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out_en <= 1'b0;
      o_phase  <= ST_OFF;
      o_ind    <= '0;
    end else begin
      o_out_en <= charging_w;
      o_phase  <= st_r;
      o_ind.out <= 4'h0;
      // released once current is below termination
      o_ind.oe[`LICS_PIN_CHG] <= chg_act_w;
      // fault pin low on temperature or pre-charge
      o_ind.oe[`LICS_PIN_FLT] <= fault_w;
      o_ind.oe[`LICS_PIN_SUP] <= c.supply_ok;
      o_ind.oe[`LICS_PIN_OVP] <= c.ovp;
    end
  end

  // axi4-lite write side: address and data taken in either order
  logic       aw_hold_r;
  logic [3:0] aw_addr_r;
  logic       w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_go_w;
  logic       wr_hit_w;

  assign o_s_axi_awready = !aw_hold_r && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_hold_r && !o_s_axi_bvalid;
  assign wr_go_w  = aw_hold_r && w_hold_r && !o_s_axi_bvalid;
  assign wr_hit_w = (aw_addr_r == `LICS_A_CTRL) ||
                    (aw_addr_r == `LICS_A_TOHM) ||
                    (aw_addr_r == `LICS_A_STAT) ||
                    (aw_addr_r == `LICS_A_TIMER);

  // capture channels, then perform and answer the write
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold_r      <= 1'b0;
      aw_addr_r      <= 4'h0;
      w_hold_r       <= 1'b0;
      w_data_r       <= 32'h0000_0000;
      w_strb_r       <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `LICS_RESP_OK;
      ctrl_en_r      <= `LICS_CTRL_RST;
      rohm_r         <= `LICS_ROHM_RST;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {i_s_axi_awaddr[3:2], 2'b00};
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= i_s_axi_wdata;
        w_strb_r <= i_s_axi_wstrb;
      end
      if (wr_go_w) begin
        aw_hold_r      <= 1'b0;
        w_hold_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_hit_w ? `LICS_RESP_OK : `LICS_RESP_ERR;
        // status and timer words ignore writes
        if (aw_addr_r == `LICS_A_CTRL && w_strb_r[0]) begin
          ctrl_en_r <= w_data_r[0];
        end
        if (aw_addr_r == `LICS_A_TOHM) begin
          rohm_r <= merge16(rohm_r, w_data_r, w_strb_r);
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  logic [31:0] rd_w;
  logic        rd_hit_w;
  assign rd_hit_w = 1'b1;
  always_comb begin
    case ({i_s_axi_araddr[3:2], 2'b00})
      `LICS_A_CTRL:  rd_w = {31'h0, ctrl_en_r};
      `LICS_A_TOHM:  rd_w = {16'h0, rohm_r};
      `LICS_A_STAT:  rd_w = {18'h0, i_ind_in, tmode_w, fault_w,
                             term_r, chg_act_w, charging_w,
                             1'b0, st_r};
      `LICS_A_TIMER: rd_w = {tlim_w, tmr_r};
      default:       rd_w = 32'h0000_0000;
    endcase
  end

  // read answer one cycle after the address is taken
  assign o_s_axi_arready = !o_s_axi_rvalid;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= `LICS_RESP_OK;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_w;
      o_s_axi_rresp  <= rd_hit_w ? `LICS_RESP_OK : `LICS_RESP_ERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end
endmodule : lics_sequencer

// file: lics_consts.svh
/*
  constants of the charge sequencer: clock, timing, register map.
  assumes a 40 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef LICS_CONSTS_SVH
`define LICS_CONSTS_SVH
// core clock rate in MHz
`define LICS_CLK_MHZ     64'd40
// supply glitch filter least time, ns
`define LICS_GLITCH_NS   64'd1000
`define LICS_GLITCH_CYC  ((`LICS_GLITCH_NS * `LICS_CLK_MHZ + 64'd999) / 64'd1000)
// charge timer base: one second, ns
`define LICS_SEC_NS      64'd1000000000
`define LICS_SEC_CYC     (`LICS_SEC_NS * `LICS_CLK_MHZ / 64'd1000)
// fixed internal timeout, seconds (3 hours)
`define LICS_T_FIXED_S   16'h2A30
// resistor timeout reset value, ohms (fixed 3 hours)
`define LICS_ROHM_RST    16'h7E90
// register byte offsets
`define LICS_A_CTRL      4'h0
`define LICS_A_TOHM      4'h4
`define LICS_A_STAT      4'h8
`define LICS_A_TIMER     4'hC
// ctrl reset: charging enabled
`define LICS_CTRL_RST    1'b1
// indicator pin bit positions
`define LICS_PIN_CHG     0
`define LICS_PIN_FLT     1
`define LICS_PIN_SUP     2
`define LICS_PIN_OVP     3
// index of the supply comparator in the sync vector
`define LICS_SUP_BIT     0
// axi responses
`define LICS_RESP_OK     2'h0
`define LICS_RESP_ERR    2'h2
`endif

// file: lics_pkg.sv
/*
  types of the charge sequencer: phases, timer modes, pin groups.
  assumes nothing beyond the consts header for numbers.
*/
package lics_pkg;
  // sequencer phases
  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_PRE  = 3'b001,
    ST_CC   = 3'b010,
    ST_CV   = 3'b011,
    ST_MON  = 3'b100,
    ST_FLT  = 3'b101,
    ST_SUSP = 3'b110
  } lics_state_t;

  // timer source
  typedef enum logic [1:0] {
    TM_OFF   = 2'b00,
    TM_FIXED = 2'b01,
    TM_RES   = 2'b10
  } lics_tmode_t;

  // comparator decisions, asynchronous to the core clock
  typedef struct packed {
    logic tsel_low;     // timer select tied to ground
    logic tsel_high;    // timer select tied to supply
    logic therm_dis;    // thermistor below disable level
    logic therm_hot;    // thermistor below hot threshold
    logic therm_cold;   // thermistor above cold threshold
    logic bat_rechg;    // battery below recharge point
    logic iout_term;    // output current below termination
    logic bat_cv;       // battery at regulation target
    logic bat_pre;      // battery above pre-charge threshold
    logic ovp;          // input over-voltage present
    logic supply_ok;    // supply above undervoltage threshold
  } lics_cmp_t;

  // open-drain indicator pins, one bit per pin
  typedef struct packed {
    logic [3:0] out;    // level driven while enabled
    logic [3:0] oe;     // high while pulling the pin
  } lics_ind_t;
endpackage : lics_pkg

// file: lics_sync.sv
/*
  two-flop synchroniser for the comparator vector, with a glitch
  filter on the supply bit.
  assumes one core clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "lics_consts.svh"
module lics_sync (
  input  wire logic               i_core_clk,
  input  wire logic               i_resetn,
  input  wire lics_pkg::lics_cmp_t i_async,
  output lics_pkg::lics_cmp_t      o_sync
);
  import lics_pkg::*;

  localparam int unsigned W = $bits(lics_cmp_t);
  localparam logic [7:0] GLITCH_CYC = 8'(`LICS_GLITCH_CYC);

  logic [W-1:0] meta_r;    // first stage, read only by stage two
  logic [W-1:0] sync_r;    // second stage
  logic         sup_r;     // filtered supply level
  logic [7:0]   cnt_r;     // cycles the raw supply differs
  logic [W-1:0] out_w;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  // supply glitch filter
  // a change must hold for the whole filter time before it counts
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sup_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (sync_r[`LICS_SUP_BIT] == sup_r) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == GLITCH_CYC - 8'h01) begin
      sup_r <= sync_r[`LICS_SUP_BIT];
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // filtered supply replaces the raw bit
  always_comb begin
    out_w = sync_r;
    out_w[`LICS_SUP_BIT] = sup_r;
  end
  assign o_sync = out_w;
endmodule : lics_sync

// file: lics_pack_model.sv
/*
  battery, adapter and thermistor model: turns levels set by the
  bench into comparator decisions and resolves the open-drain pins.
  assumes the bench changes its levels just after a clock edge.
*/
`timescale 1ns/1ps
module lics_pack_model (
  input  wire logic                i_supply,  // adapter present
  input  wire logic                i_ovp,     // adapter over-voltage
  input  wire logic [12:0]         i_bat_mv,  // battery voltage, mV
  input  wire logic [11:0]         i_iout_ma, // current while on, mA
  input  wire logic [1:0]          i_ntc,     // 0 ok 1 hot 2 cold 3 off
  input  wire logic [1:0]          i_tsel,    // 0 res 1 supply 2 ground
  input  wire logic                i_out_en,  // charger output on
  input  wire lics_pkg::lics_ind_t i_ind,     // chip pin drivers
  output lics_pkg::lics_cmp_t      o_cmp,     // comparator levels
  output logic [3:0]               o_pins     // resolved pin levels
);
  import lics_pkg::*;
  // pack thresholds, plain defaults
  localparam int PRE_MV = 3000;
  localparam int CV_MV  = 4200;
  localparam int RCH_MV = 4100;
  localparam int TRM_MA = 100;
  assign o_cmp.supply_ok  = i_supply;
  assign o_cmp.ovp        = i_ovp;
  assign o_cmp.bat_pre    = i_bat_mv >= 13'(PRE_MV);
  assign o_cmp.bat_cv     = i_bat_mv >= 13'(CV_MV);
  assign o_cmp.bat_rechg  = i_bat_mv < 13'(RCH_MV);
  // no current flows while the output is off
  assign o_cmp.iout_term  = !i_out_en || i_iout_ma < 12'(TRM_MA);
  assign o_cmp.therm_hot  = i_ntc == 2'h1;
  assign o_cmp.therm_cold = i_ntc == 2'h2;
  assign o_cmp.therm_dis  = i_ntc == 2'h3;
  assign o_cmp.tsel_high  = i_tsel == 2'h1;
  assign o_cmp.tsel_low   = i_tsel == 2'h2;
  // pull-ups hold each pin high unless the chip sinks it
  assign o_pins = ~i_ind.oe;
endmodule : lics_pack_model

// file: lics_seq_checker.sv
/*
  assertions on the charge sequencer, bound to its top ports.
  assumes comparator levels are held for several cycles.
*/
`timescale 1ns/1ps
module lics_seq_checker #(
  parameter int unsigned P_SEC_CYC = 10
) (
  input wire logic                  i_core_clk,
  input wire logic                  i_resetn,
  input wire lics_pkg::lics_cmp_t   i_cmp,
  input wire lics_pkg::lics_ind_t   o_ind,
  input wire lics_pkg::lics_state_t o_phase,
  input wire logic                  o_out_en
);
  import lics_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic [5:0] hi_r, lo_r;   // supply run lengths, saturating
  wire  [5:0] hi_nxt = !i_cmp.supply_ok ? 6'h00 : hi_r + {5'h00, ~&hi_r};
  wire  [5:0] lo_nxt = i_cmp.supply_ok ? 6'h00 : lo_r + {5'h00, ~&lo_r};
  wire  off_ph = o_phase inside {ST_OFF, ST_MON, ST_FLT, ST_SUSP};
  wire  tbad = i_cmp.therm_hot | i_cmp.therm_cold;
  // counters outlast the supply glitch filter
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_r <= 6'h00;
      lo_r <= 6'h00;
    end else begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end
  out_idle_a:
    assert property (off_ph [*2] |-> !o_out_en) else $error("output on");
  chg_rel_a:
    assert property ((!o_out_en) [*2] |-> !o_ind.oe[0])
    else $error("charge-active held with output off");
  sup_on_a:
    assert property (hi_r == 6'h3F |-> o_ind.oe[2])
    else $error("supply-present not driven");
  sup_off_a:
    assert property (lo_r == 6'h3F |-> !o_ind.oe[2] && o_phase == ST_OFF)
    else $error("running without supply");
  ovp_a:
    assert property (i_cmp.ovp [*8] |-> o_ind.oe[3])
    else $error("over-voltage not shown");
  dis_a:
    assert property (i_cmp.therm_dis [*6] |-> o_phase == ST_OFF
                     && !o_ind.oe[1]) else $error("disable not obeyed");
  susp_a:
    assert property ($rose(tbad) && o_out_en && !i_cmp.therm_dis
                     |-> ##[1:6] o_phase == ST_SUSP) else $error("no suspend");
  susp_flt_a:
    assert property ((o_phase == ST_SUSP && tbad && i_cmp.supply_ok) [*4]
      |-> o_ind.oe[1] && !o_out_en) else $error("suspend without fault");
  resume_a:
    assert property (o_phase == ST_SUSP && !tbad ##1 (!tbad) [*7]
                     |-> o_phase != ST_SUSP) else $error("no resume");
  flt_a:
    assert property (o_phase == ST_FLT [*2] |-> o_ind.oe[1] && !o_out_en)
    else $error("pre-charge fault not shown");
  term_a:
    assert property ((o_out_en && i_cmp.iout_term) [*6] |-> !o_ind.oe[0])
    else $error("charge-active kept below termination");
  stop_a:
    assert property ((o_phase == ST_CV && i_cmp.tsel_low && i_cmp.iout_term
      && !tbad) [*6] |-> ##[1:2] o_phase == ST_MON) else $error("no stop");
  pre_cc_a:
    assert property ((o_phase == ST_PRE && i_cmp.bat_pre && !tbad) [*6]
      |-> ##[1:2] o_phase == ST_CC) else $error("pre-charge kept");
endmodule : lics_seq_checker
bind lics_sequencer lics_seq_checker #(.P_SEC_CYC(P_SEC_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cmp(i_cmp),
  .o_ind(o_ind), .o_phase(o_phase), .o_out_en(o_out_en));

// file: lics_sequencer_bench.sv
/*
  bench for the charge sequencer: registers over AXI4-Lite, pack
  levels through the model, phases and pins checked per step.
  assumes one second of timer is shortened to 10 cycles.
*/
`timescale 1ns/1ps
module lics_sequencer_bench;
  import lics_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0;  // 40 MHz clock, reset
  logic        sup = 1'b0, ovp = 1'b0;   // adapter levels
  logic [12:0] bat = 13'd2800;           // battery, mV
  logic [11:0] iout = 12'd500;           // current when on, mA
  logic [1:0]  ntc = 2'd0, tsel = 2'd0;  // thermistor, timer select
  logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, ws = 4'hF;
  logic [31:0] wdat = 32'h0, v, t1, t2, rdat;
  logic        awr, wrd, bv, arr, rv, oen;
  logic [3:0]  pins;
  logic [1:0]  brsp, rrsp;               // write and read responses
  lics_cmp_t   cmp;
  lics_ind_t   ind;
  lics_state_t ph;
  int          fail_count = 0, n_tests = 0, k;
  always #12.5 clk = ~clk;
  lics_sequencer #(.P_SEC_CYC(10)) uut (
    .i_core_clk(clk), .i_resetn(rstn), .i_cmp(cmp), .i_ind_in(pins),
    .o_ind(ind), .o_phase(ph), .o_out_en(oen),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wdat),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(brd),
    .o_s_axi_bresp(brsp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rrsp));
  lics_pack_model pack (.i_supply(sup), .i_ovp(ovp), .i_bat_mv(bat),
    .i_iout_ma(iout), .i_ntc(ntc), .i_tsel(tsel), .i_out_en(oen),
    .i_ind(ind), .o_cmp(cmp), .o_pins(pins));
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // each channel holds valid until its own ready is seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wdat <= d;
    brd <= 1'b1;
    do begin
      @(posedge clk);
      if (!ad && awr) begin
        awv <= 1'b0;
        ad = 1;
      end
      if (!dd && wrd) begin
        wv <= 1'b0;
        dd = 1;
      end
    end while (!bv);
    brd <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bit ad;
    ad = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    do begin
      @(posedge clk);
      if (!ad && arr) begin
        arv <= 1'b0;
        ad = 1;
      end
    end while (!rv);
    d = rdat;
    rrd <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask : rchk
  // bounded wait for a phase, then compare it
  task automatic wph(input lics_state_t p, input int n);
    for (int i = 0; i < n && ph !== p; i++) @(posedge clk);
    chk({29'h0, ph}, {29'h0, p});
  endtask : wph
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  initial begin
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    rchk(4'h4, 32'hFFFF, 32'h7E90);
    rchk(4'h8, 32'h7, 32'h0);
    tsel <= 2'd1;
    cyc(6);
    rchk(4'hC, 32'hFFFF0000, 32'h2A300000);
    rchk(4'h8, 32'h300, 32'h100);
    tsel <= 2'd2;
    cyc(6);
    rchk(4'h8, 32'h300, 32'h0);
    tsel <= 2'd0;
    wr(4'h4, 32'd240);
    chk({30'h0, brsp}, 32'h0);
    rchk(4'hC, 32'hFFFF0000, 32'h00500000);
    chk({30'h0, rrsp}, 32'h0);
    wr(4'hC, 32'h0);
    rchk(4'hC, 32'hFFFF0000, 32'h00500000);
    sup <= 1'b1;
    cyc(20);
    wph(ST_OFF, 0);
    wph(ST_PRE, 60);
    // charge-active needs the output-on current to pass the synchroniser
    cyc(4);
    chk({28'h0, ind.oe}, 32'h5);
    cyc(170);
    wph(ST_PRE, 0);
    wph(ST_FLT, 60);
    chk({30'h0, oen, ind.oe[1]}, 32'h1);
    rchk(4'h8, 32'h3FFF, 32'h2685);
    bat <= 13'd3500;
    wph(ST_CC, 8);
    for (k = 1; k < 3; k++) begin
      ntc <= 2'(k);
      wph(ST_SUSP, 8);
      cyc(2);
      chk({29'h0, oen, ind.oe[1:0]}, 32'h2);
      rd(4'hC, t1);
      cyc(60);
      rd(4'hC, t2);
      chk(t2, t1);
      ntc <= 2'd0;
      wph(ST_CC, 8);
      rd(4'hC, t2);
      chk({31'h0, t2[15:0] - t1[15:0] < 16'h2}, 32'h1);
    end
    bat <= 13'd4200;
    wph(ST_CV, 8);
    iout <= 12'd50;
    cyc(8);
    wph(ST_CV, 0);
    chk({31'h0, ind.oe[0]}, 32'h0);
    wph(ST_MON, 900);
    chk({30'h0, oen, ind.oe[1]}, 32'h0);
    rchk(4'hC, 32'hFFFF, 32'h50);
    rchk(4'h8, 32'h3FFF, 32'h2E44);
    bat <= 13'd4150;
    cyc(10);
    wph(ST_MON, 0);
    bat <= 13'd4050;
    wph(ST_CC, 8);
    rd(4'hC, v);
    chk({31'h0, v[15:0] < 16'h2}, 32'h1);
    tsel <= 2'd2;
    bat <= 13'd4200;
    wph(ST_MON, 20);
    tsel <= 2'd0;
    bat <= 13'd2800;
    wph(ST_PRE, 10);
    cyc(40);
    ntc <= 2'd3;
    wph(ST_OFF, 8);
    cyc(4);
    chk({31'h0, ind.oe[1]}, 32'h0);
    rchk(4'hC, 32'hFFFF, 32'h0);
    ntc <= 2'd0;
    ovp <= 1'b1;
    cyc(10);
    chk({31'h0, ind.oe[3]}, 32'h1);
    ovp <= 1'b0;
    cyc(10);
    chk({31'h0, ind.oe[3]}, 32'h0);
    // software disable acts like the thermistor disable level
    wr(4'h0, 32'h0);
    wph(ST_OFF, 8);
    rchk(4'h0, 32'h1, 32'h0);
    wr(4'h0, 32'h1);
    wph(ST_PRE, 8);
    // a supply dip shorter than the filter must not end the cycle
    sup <= 1'b0;
    cyc(10);
    sup <= 1'b1;
    cyc(50);
    wph(ST_PRE, 0);
    sup <= 1'b0;
    cyc(70);
    chk({28'h0, ind.oe}, 32'h0);
    wph(ST_OFF, 0);
    close_out;
  end
  // cut a hang short well past the expected run length
  initial begin
    cyc(20000);
    fail_count++;
    close_out;
  end
endmodule : lics_sequencer_bench
